// File: core/dcb_pkg.sv
// Package for the DMA setup and byte counter block
// Assumes a byte-wide register port with byte offsets as addresses
package dcb_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] CNT_B1_OFS = 8'h34;
    localparam logic [7:0] CNT_B2_OFS = 8'h35;
    localparam logic [7:0] CNT_B3_OFS = 8'h36;
    localparam logic [7:0] CNT_B4_OFS = 8'h37;
    localparam logic [7:0] SETUP_LO_OFS = 8'h38;
    localparam logic [7:0] SETUP_HI_OFS = 8'h39;
    localparam logic [7:0] CTRL_OFS = 8'h3A;
    localparam logic [7:0] STAT_OFS = 8'h3B;
    // ==========================================
    // Field positions of the setup register
    localparam int SKIP_READY_BIT = 14;
    localparam int ATA_PATH_BIT = 13;
    localparam int TIMING_LSB = 11;
    localparam int PIO_LSB = 8;
    localparam int BYPASS_BIT = 7;
    localparam int BURST_LSB = 4;
    localparam int STROBE_LSB = 2;
    localparam int WIDTH_BIT = 0;
    localparam logic [15:0] SETUP_RW_MASK = 16'h7FFD;
    localparam logic [15:0] SETUP_RESET = 16'h0001;
    localparam logic [31:0] COUNT_RESET = 32'h00000000;
    localparam logic [2:0] PIO_MAX = 3'h4;
    localparam logic [1:0] STROBE_ACK_BOTH = 2'h2;
    localparam logic [1:0] STROBE_RESERVED = 2'h3;
    localparam int FIFO_DEPTH = 4;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic skip_ready_wait;
        logic ata_path_select;
        logic [1:0] dma_timing;
        logic [2:0] programmed_io_timing;
        logic counter_bypass;
        logic [2:0] burst;
        logic [1:0] strobe_assign;
        logic bus_wide;
    } dcb_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ = 3'b010,
        ST_GAP = 3'b100
    } dcb_state_e;
endpackage

// File: core/dcb_fifo.sv
// FIFO on the data path between the DMA bus and the endpoint side
// Assumes one clock; both sides use valid and ready
`timescale 1ns/1ps
module dcb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = fill < (AW+1)'(DEPTH);
    assign out_valid = fill != '0;
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: core/dcb_core.sv
// DMA setup register and transfer byte counter with generic slave request pacing
// Assumes a byte register port; DMA pins are asynchronous and pass two flip-flops, ready_pin three
//
// Overview of operation
// - Byte count is 32 bits, byte one lowest.
// - Two-byte setup register configures the DMA core.
// - Bit 14 ignores ready input in UDMA.
// - Timing values 0-2 select modes 0-2.
// - Timing value 3 selects MDMA programmable strobes in master mode.
// - Bits 10:8 select Programmed_io_timing 0-4.
// - Bit 7 bypasses counter, generic slave only.
// - Burst 0 holds request until end/FIFO limit.
// - Burst 1-7 pulses request per group.
// - Counter loads when top byte is written.
// - Request only with FIFO room for inbound data.
// - Acknowledge-both strobing needs the 16-bit bus.
// - Bit 0 selects 8 or 16-bit bus.
`timescale 1ns/1ps
module dcb_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic bus_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic master_mode,
    input wire logic udma_active,
    input wire logic ready_pin,
    input wire logic ack_pin,
    input wire logic eot_pin,
    input wire logic [15:0] bus_data_in,
    output logic dma_req,
    output logic xfer_done,
    output logic ready_ok,
    output logic [1:0] dma_timing,
    output logic [2:0] programmed_io_timing,
    output logic strobe_table_en,
    output logic ata_path_select,
    output logic [1:0] strobe_assign,
    output logic bus_wide,
    output logic data_valid,
    input wire logic data_ready,
    output logic [15:0] data_out
);
    import dcb_pkg::*;

    // ==========================================
    // Registers and decode
    logic [15:0] setup;
    logic [31:0] count_shadow;
    logic [31:0] dma_byte_count;
    logic counter_live;
    logic [15:0] next_setup;
    dcb_cfg_s cfg;
    dcb_state_e state;
    logic [5:0] group_cnt;
    logic [2:0] ready_sync;
    logic [2:0] ack_sync;
    logic [1:0] eot_sync;
    logic [7:0] next_rdata;
    logic done_flag;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = a == ofs;
    endfunction

    function automatic logic [5:0] burst_len(input logic [2:0] b);
        case (b)
            3'h1: burst_len = 6'h01;
            3'h2: burst_len = 6'h02;
            3'h3: burst_len = 6'h04;
            3'h4: burst_len = 6'h08;
            3'h5: burst_len = 6'h0C;
            3'h6: burst_len = 6'h10;
            3'h7: burst_len = 6'h20;
            default: burst_len = 6'h00;
        endcase
    endfunction

    assign cfg = '{skip_ready_wait: setup[SKIP_READY_BIT], ata_path_select: setup[ATA_PATH_BIT],
        dma_timing: setup[TIMING_LSB +: 2], programmed_io_timing: setup[PIO_LSB +: 3],
        counter_bypass: setup[BYPASS_BIT], burst: setup[BURST_LSB +: 3],
        strobe_assign: setup[STROBE_LSB +: 2], bus_wide: setup[WIDTH_BIT]};

    wire wr_lo = reg_wr && hit(reg_addr, SETUP_LO_OFS);
    wire wr_hi = reg_wr && hit(reg_addr, SETUP_HI_OFS);
    wire [15:0] wr_word = wr_lo ? {setup[15:8], reg_wdata} : {reg_wdata, setup[7:0]};
    // Reserved setup bits never store
    assign next_setup = (wr_lo || wr_hi) ? (wr_word & SETUP_RW_MASK) : setup;

    // Counter bypass only counts in generic slave mode
    wire count_bypassed = cfg.counter_bypass && !master_mode;
    wire ready_in = ready_sync[2];
    wire ack_rise = ack_sync[1] && !ack_sync[2];
    wire eot_seen = eot_sync[1];
    wire fifo_in_ready;
    wire beat = ack_rise && fifo_in_ready;
    wire [31:0] beat_bytes = cfg.bus_wide ? 32'h00000002 : 32'h00000001;
    wire count_hits_zero = counter_live && !count_bypassed && (dma_byte_count <= beat_bytes);
    wire [5:0] group_len = burst_len(cfg.burst);
    // Request needs FIFO room for inbound data
    wire can_req = fifo_in_ready && !done_flag;
    wire group_end = (cfg.burst != 3'h0) && beat && (group_cnt + 6'h01 >= group_len);

    // ==========================================
    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr)
            CNT_B1_OFS: next_rdata = dma_byte_count[7:0];
            CNT_B2_OFS: next_rdata = dma_byte_count[15:8];
            CNT_B3_OFS: next_rdata = dma_byte_count[23:16];
            CNT_B4_OFS: next_rdata = dma_byte_count[31:24];
            SETUP_LO_OFS: next_rdata = setup[7:0];
            SETUP_HI_OFS: next_rdata = setup[15:8];
            STAT_OFS: next_rdata = {5'h00, counter_live, state == ST_REQ, done_flag};
            default: next_rdata = 8'h00;
        endcase
    end

    // ==========================================
    // Setup register and read data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setup <= SETUP_RESET;
            reg_rdata <= 8'h00;
        end else if (bus_reset) begin
            setup <= SETUP_RESET;
            reg_rdata <= 8'h00;
        end else begin
            setup <= next_setup;
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ==========================================
    // Byte counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_shadow <= COUNT_RESET;
            dma_byte_count <= COUNT_RESET;
            counter_live <= 1'b0;
            done_flag <= 1'b0;
        end else if (bus_reset) begin
            count_shadow <= COUNT_RESET;
            dma_byte_count <= COUNT_RESET;
            counter_live <= 1'b0;
            done_flag <= 1'b0;
        end else begin
            if (reg_wr && hit(reg_addr, CNT_B1_OFS)) count_shadow[7:0] <= reg_wdata;
            if (reg_wr && hit(reg_addr, CNT_B2_OFS)) count_shadow[15:8] <= reg_wdata;
            if (reg_wr && hit(reg_addr, CNT_B3_OFS)) count_shadow[23:16] <= reg_wdata;
            if (reg_wr && hit(reg_addr, CNT_B4_OFS)) begin
                // Only the top byte arms the counter
                dma_byte_count <= {reg_wdata, count_shadow[23:0]};
                counter_live <= 1'b1;
                done_flag <= 1'b0;
            end else if (beat && counter_live && !count_bypassed) begin
                dma_byte_count <= count_hits_zero ? 32'h00000000 : dma_byte_count - beat_bytes;
                if (count_hits_zero) begin
                    counter_live <= 1'b0;
                    done_flag <= 1'b1;
                end
            end else if (beat && count_bypassed && eot_seen) begin
                done_flag <= 1'b1;
            end
        end
    end

    // ==========================================
    // Request pacing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            group_cnt <= 6'h00;
        end else if (bus_reset) begin
            state <= ST_IDLE;
            group_cnt <= 6'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    group_cnt <= 6'h00;
                    if (can_req && (counter_live || count_bypassed) && !master_mode) state <= ST_REQ;
                end
                ST_REQ: begin
                    if (!can_req || count_hits_zero && beat) begin
                        state <= ST_IDLE;
                    end else if (group_end) begin
                        state <= ST_GAP;
                        group_cnt <= 6'h00;
                    end else if (beat) begin
                        group_cnt <= group_cnt + 6'h01;
                    end
                end
                ST_GAP: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Synchronisers and registered outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ready_sync <= 3'h0;
            ack_sync <= 3'h0;
            eot_sync <= 2'h0;
            dma_req <= 1'b0;
            xfer_done <= 1'b0;
            ready_ok <= 1'b0;
            dma_timing <= 2'h0;
            programmed_io_timing <= 3'h0;
            strobe_table_en <= 1'b0;
            ata_path_select <= 1'b0;
            strobe_assign <= 2'h0;
            bus_wide <= 1'b1;
        end else begin
            ready_sync <= {ready_sync[1:0], ready_pin};
            ack_sync <= {ack_sync[1:0], ack_pin};
            eot_sync <= {eot_sync[0], eot_pin};
            dma_req <= state == ST_REQ;
            xfer_done <= done_flag;
            // Ready wait is skipped only in UDMA
            ready_ok <= (cfg.skip_ready_wait && udma_active) || ready_in;
            dma_timing <= cfg.dma_timing;
            strobe_table_en <= (cfg.dma_timing == 2'h3) && master_mode;
            // Reserved PIO codes clamp to the slowest safe mode
            programmed_io_timing <= (cfg.programmed_io_timing > PIO_MAX) ? 3'h0 : cfg.programmed_io_timing;
            ata_path_select <= cfg.ata_path_select;
            // Acknowledge-both falls back on an 8-bit bus
            strobe_assign <= (cfg.strobe_assign == STROBE_RESERVED) ||
                (cfg.strobe_assign == STROBE_ACK_BOTH && !cfg.bus_wide) ? 2'h0 : cfg.strobe_assign;
            bus_wide <= cfg.bus_wide;
        end
    end

    // ==========================================
    // Data buffer
    dcb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(beat),
        .in_ready(fifo_in_ready),
        .in_data(bus_data_in),
        .out_valid(data_valid),
        .out_ready(data_ready),
        .out_data(data_out)
    );
endmodule

// File: verification/dcb_core_properties.sv
// Concurrent checks on the ports of the DMA setup and byte counter block
// Assumes the dcb_pkg register map and registered decode outputs
`timescale 1ns/1ps
module dcb_core_check
    import dcb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic bus_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] dma_timing,
    input wire logic [2:0] programmed_io_timing,
    input wire logic strobe_table_en,
    input wire logic ata_path_select,
    input wire logic [1:0] strobe_assign,
    input wire logic bus_wide
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // Setup write steps
    sequence s_hi_wr;
        reg_wr && reg_addr == SETUP_HI_OFS && !bus_reset;
    endsequence
    sequence s_hi_quiet;
        !(reg_wr && reg_addr == SETUP_HI_OFS) && !bus_reset;
    endsequence
    sequence s_lo_wr;
        reg_wr && reg_addr == SETUP_LO_OFS && !bus_reset;
    endsequence
    sequence s_lo_quiet;
        !(reg_wr && reg_addr == SETUP_LO_OFS) && !bus_reset;
    endsequence
    // ==========================================
    // Assertions
    a_ata_follow: assert property (s_hi_wr ##1 s_hi_quiet [*2] |=>
        ata_path_select == $past(reg_wdata[5], 3) && dma_timing == $past(reg_wdata[4:3], 3))
        else $error("path or timing not taken from setup write");
    a_width_follow: assert property (s_lo_wr ##1 s_lo_quiet [*2] |=>
        bus_wide == $past(reg_wdata[0], 3)) else $error("bus width not taken from setup write");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    a_resv_zero: assert property (reg_rd && reg_addr == SETUP_HI_OFS |=> !reg_rdata[7])
        else $error("reserved setup bit read as one");
    a_pio_legal: assert property (programmed_io_timing <= PIO_MAX)
        else $error("reserved io timing mode used");
    a_strobe_legal: assert property (strobe_assign != STROBE_RESERVED &&
        (strobe_assign != STROBE_ACK_BOTH || bus_wide)) else $error("illegal strobe assignment");
    a_table_mode: assert property (strobe_table_en |-> dma_timing == 2'h3)
        else $error("strobe table on outside mode three");
    a_bus_clear: assert property (bus_reset [*2] |=> bus_wide && !ata_path_select &&
        dma_timing == 2'h0 && programmed_io_timing == 3'h0) else $error("bus reset left setup");
endmodule

bind dcb_core dcb_core_check chk_i (.clk, .resetn, .bus_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dma_timing, .programmed_io_timing, .strobe_table_en, .ata_path_select, .strobe_assign, .bus_wide);

// File: verification/dcb_far_side.sv
// Model of the external DMA controller that answers requests
// Assumes active-high pins; the bench reads the sent queue
`timescale 1ns/1ps
module dcb_far_side (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic dma_req,
    output logic ready_pin,
    output logic ack_pin,
    output logic [15:0] bus_data_in
);
    logic [15:0] sent[$];
    logic [15:0] word;
    initial begin
        ready_pin = 1'b0;
        ack_pin = 1'b0;
        bus_data_in = 16'h0000;
        forever begin
            @(posedge clk);
            // Drive reports ready only while the link is in use
            ready_pin <= enable;
            if (resetn && enable && dma_req) begin
                word = 16'($urandom);
                sent.push_back(word);
                bus_data_in <= word;
                ack_pin <= 1'b1;
                repeat (4) @(posedge clk);
                ack_pin <= 1'b0;
                @(posedge clk);
                // Released bus shows the inverse, random gap
                bus_data_in <= ~word;
                repeat (1 + $urandom % 4) @(posedge clk);
            end else begin
                bus_data_in <= ~bus_data_in;
            end
        end
    end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the DMA setup and byte counter block
// Assumes dcb_core with dcb_far_side on the DMA pins
`timescale 1ns/1ps
module testbench;
    import dcb_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic bus_reset = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic master_mode = 1'b0;
    logic udma_active = 1'b0;
    logic eot_pin = 1'b0;
    logic data_ready = 1'b0;
    logic far_en = 1'b0;
    logic ready_pin, ack_pin, dma_req, xfer_done, ready_ok, strobe_table_en, ata_path_select, bus_wide, data_valid;
    logic [7:0] reg_rdata;
    logic [15:0] bus_data_in, data_out;
    logic [1:0] dma_timing, strobe_assign;
    logic [2:0] programmed_io_timing;
    int bad_count = 0;
    int check_count = 0;
    always #10 clk = ~clk;
    dcb_core dut (.clk, .resetn, .bus_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .master_mode,
        .udma_active, .ready_pin, .ack_pin, .eot_pin, .bus_data_in, .dma_req, .xfer_done, .ready_ok, .dma_timing,
        .programmed_io_timing, .strobe_table_en, .ata_path_select, .strobe_assign, .bus_wide, .data_valid,
        .data_ready, .data_out);
    dcb_far_side far (.clk, .resetn, .enable(far_en), .dma_req, .ready_pin, .ack_pin, .bus_data_in);
    // ==========================================
    // Helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic count_io(input logic wr_en, inout logic [31:0] c);
        for (int k = 0; k < 4; k++) begin
            if (wr_en) wr(8'(CNT_B1_OFS + k), c[8*k +: 8]);
            else rd(8'(CNT_B1_OFS + k), c[8*k +: 8]);
        end
    endtask
    function automatic logic [8:0] exp_setup(input logic [15:0] v);
        logic [1:0] s;
        s = v[3:2];
        if (s == STROBE_RESERVED || (s == STROBE_ACK_BOTH && !v[0])) s = 2'h0;
        return {v[13], v[12:11], v[10:8] > PIO_MAX ? 3'h0 : v[10:8], s, v[0]};
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        test_done;
    end
    // ==========================================
    // Tests
    initial begin
        logic [15:0] v;
        logic [15:0] word;
        logic [15:0] m;
        logic [31:0] c;
        logic [7:0] b;
        int t;
        void'($urandom(32'h0BB0));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 6; a++) begin
            rd(8'(CNT_B1_OFS + a), b);
            chk("reset value", b, a == 4 ? 8'h01 : 8'h00);
        end
        wr(8'h50, 8'hFF);
        rd(8'h50, b);
        chk("unmapped", b, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            v = i == 0 ? 16'hFFFF : i == 1 ? 16'h0D08 : 16'($urandom);
            udma_active <= v[15];
            master_mode <= v[1];
            wr(SETUP_LO_OFS, v[7:0]);
            wr(SETUP_HI_OFS, v[15:8]);
            rd(SETUP_LO_OFS, b);
            chk("setup low", b, v[7:0] & SETUP_RW_MASK[7:0]);
            rd(SETUP_HI_OFS, b);
            chk("setup high", b, v[15:8] & SETUP_RW_MASK[15:8]);
            chk("decode", {ata_path_select, dma_timing, programmed_io_timing, strobe_assign, bus_wide},
                exp_setup(v));
            chk("ready ok", ready_ok, v[14] && v[15]);
            chk("strobe table", strobe_table_en, (v[12:11] == 2'h3) && v[1]);
        end
        master_mode <= 1'b0;
        $display("test setup done");
        c = $urandom;
        v = c[15:0];
        word = c[31:16];
        count_io(1'b1, c);
        count_io(1'b0, c);
        chk("count", c, {word, v});
        bus_reset <= 1'b1;
        repeat (2) @(posedge clk);
        bus_reset <= 1'b0;
        #1;
        rd(SETUP_LO_OFS, b);
        chk("bus reset", b, 8'h01);
        $display("test count done");
        far_en <= 1'b1;
        for (int bu = 0; bu < 8; bu++) begin
            m = bu[0] ? 16'hFFFF : 16'h00FF;
            wr(SETUP_LO_OFS, {1'b0, 3'(bu), 3'h0, bu[0]});
            wr(SETUP_HI_OFS, 8'h00);
            c = bu[0] ? 32'h0000000A : 32'h00000005;
            count_io(1'b1, c);
            repeat (80) @(posedge clk);
            #1;
            chk("request while full", dma_req, 1'b0);
            for (int w = 0; w < 5; w++) begin
                t = 0;
                while (data_valid !== 1'b1 && t < 200) begin
                    @(posedge clk);
                    #1;
                    t++;
                end
                word = far.sent.size() ? far.sent.pop_front() : 16'hXXXX;
                chk("data", data_out & m, word & m);
                data_ready <= 1'b1;
                @(posedge clk);
                data_ready <= 1'b0;
                repeat (1 + $urandom % 3) @(posedge clk);
                #1;
            end
            t = 0;
            while (xfer_done !== 1'b1 && t < 200) begin
                @(posedge clk);
                #1;
                t++;
            end
            chk("done", xfer_done, 1'b1);
            count_io(1'b0, c);
            chk("count left", c, 32'h00000000);
            chk("extra words", far.sent.size(), 32'h00000000);
        end
        $display("test transfer done");
        test_done;
    end
endmodule
